// ### testbench/p2s_host_model.sv
// host controller model: slowed pixel clock and word pins
`timescale 1ns/1ps
module p2s_host_model #(
    parameter int PER = 14
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [p2s_pkg::WORD_W-1:0] word_src,
    output logic host_pixel_clock,
    output logic [p2s_pkg::WORD_W-1:0] parallel_word_in
);
    int cnt;
    // rate cut far below the real band: seven slots need seven clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            host_pixel_clock <= 1'b0;
            parallel_word_in <= '0;
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            // high half the period, word changes on rise so fall sees it
            host_pixel_clock <= (cnt < PER / 2);
            if (cnt == 0) begin
                parallel_word_in <= word_src;
            end
        end
    end
endmodule : p2s_host_model

// ### testbench/p2s_top_bench.sv
// self-checking bench of the 21-to-3 serializer
`timescale 1ns/1ps
module p2s_top_bench;
    localparam int LOCK = 16;
    localparam int PER = 14;
    localparam int LIMIT = 6000;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic power_down_clear_n = 1'b1;
    logic [p2s_pkg::WORD_W-1:0] word_src = '0;
    logic host_pixel_clock;
    logic [p2s_pkg::WORD_W-1:0] parallel_word_in;
    logic [p2s_pkg::LANES-1:0] serial_lane_pair;
    logic forwarded_lane_clock;
    logic lane_drive_oe_n;
    wire [4:0] outs = {serial_lane_pair, forwarded_lane_clock, lane_drive_oe_n};
    logic [20:0] corner [4] = '{21'h000000, 21'h1FFFFF,
        21'h155555, 21'h0AAAAA};
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    p2s_host_model #(.PER(PER)) host (.clock(clock), .resetn(resetn),
        .word_src(word_src), .host_pixel_clock(host_pixel_clock),
        .parallel_word_in(parallel_word_in));
    p2s_top #(.LOCK_CYCLES(LOCK)) DUT (.clock(clock), .resetn(resetn),
        .host_pixel_clock(host_pixel_clock),
        .parallel_word_in(parallel_word_in),
        .power_down_clear_n(power_down_clear_n),
        .serial_lane_pair(serial_lane_pair),
        .forwarded_lane_clock(forwarded_lane_clock),
        .lane_drive_oe_n(lane_drive_oe_n));

    initial begin
        forever #2 clock = ~clock;
    end

    function automatic logic [2:0] exp_lanes(input logic [20:0] w,
        input int s);
        return {w[14 + s], w[7 + s], w[s]};
    endfunction : exp_lanes

    task automatic stop_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one forwarded period read slot by slot as a receiver would
    task automatic frame(input bit judge);
        logic [20:0] w;
        logic p;
        int hi;
        int i;
        hi = 0;
        i = 0;
        do begin
            p = forwarded_lane_clock;
            @(posedge clock);
            #1;
            i++;
        end while (!(p === 1'b0 && forwarded_lane_clock === 1'b1) && i < 40);
        w = parallel_word_in;
        for (i = 0; i < PER; i++) begin
            if (i > 0) begin
                @(posedge clock);
                #1;
            end
            hi += (forwarded_lane_clock === 1'b1);
            if (judge && i % 2 == 0) begin
                chk(serial_lane_pair, exp_lanes(w, i / 2));
            end
        end
        @(posedge clock);
        #1;
        if (judge) begin
            chk(forwarded_lane_clock, 1'b1);
            chk(hi, PER * 4 / 7);
            chk(lane_drive_oe_n, 1'b0);
        end
    endtask : frame

    // lanes stay quiet until the lock timer expires
    task automatic wake;
        repeat (LOCK / 2) @(posedge clock);
        #1;
        chk({serial_lane_pair, lane_drive_oe_n}, 4'h1);
        repeat (LOCK + 4) @(posedge clock);
        frame(1'b0);
        frame(1'b0);
    endtask : wake

    task automatic run_words(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            if (k < 4) begin
                word_src <= corner[k];
            end else begin
                word_src <= p2s_pkg::WORD_W'($urandom());
            end
            frame(1'b1);
        end
    endtask : run_words

    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(99));
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        wake();
        run_words(24);
        @(posedge clock);
        power_down_clear_n <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk(outs, 5'h01);
        repeat (PER) @(posedge clock);
        #1;
        chk(outs, 5'h01);
        @(posedge clock);
        power_down_clear_n <= 1'b1;
        wake();
        run_words(12);
        stop_test();
    end
endmodule : p2s_top_bench

// ### verilog/p2s_pkg.sv
// shared constants and carrier types of the 21-to-3 serializer
package p2s_pkg;
    localparam int LANES = 3;
    localparam int SLOTS = 7;
    localparam int WORD_W = LANES * SLOTS;
    localparam int HIGH_SLOTS = 4;
    localparam int PER_W = 8;
    localparam int LOCK_W = 20;
    localparam int CLK_FREQ_MHZ = 250;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int LOCK_TIME_MS = 1;
    localparam int LOCK_CYCLES_DFLT = LOCK_TIME_MS * 1000 * CLK_FREQ_MHZ;
    localparam int OFF_TIME_PS = 6500;
    localparam int OFF_CYCLES_RAW = OFF_TIME_PS / CLK_PERIOD_PS;
    localparam int OFF_CYCLES = (OFF_CYCLES_RAW < 1) ? 1 : OFF_CYCLES_RAW;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [2:0] SLOT_HIGH_END = 3'h4;
    localparam logic [PER_W-1:0] PER_MAX = 8'hFF;
    localparam logic [PER_W:0] SLOT_STEP = 9'h007;

    typedef enum logic [2:0] {
        P2S_OFF = 3'h1,
        P2S_ACQUIRE = 3'h2,
        P2S_RUN = 3'h4
    } p2s_fsm_e;

    typedef struct packed {
        logic [LANES-1:0] lane;
        logic fclk;
        logic oe_n;
    } p2s_link_s;

    typedef struct packed {
        logic pclk;
        logic [WORD_W-1:0] word;
        logic pd_n;
    } p2s_pins_s;
endpackage : p2s_pkg

// ### verilog/p2s_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module p2s_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } p2s_sync_s;

    p2s_sync_s s;
    p2s_sync_s next_s;

    // the first stage feeds only the second stage
    always_comb begin
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule : p2s_sync

// ### verilog/p2s_top.sv
// 21-bit parallel to three 7-slot serial lanes with forwarded clock
`timescale 1ns/1ps
// Function
// RULE1: three 7-bit load-and-shift registers carry 21 bits per cycle
// RULE2: all 21 input bits captured on each falling pixel clock edge
// RULE3: slot timing derived from measured input period, seven slots each
// RULE4: forwarded clock has the input clock frequency and phase; the code raises it three clocks after each falling input edge
// RULE5: shutdown low stops clocking and turns all output drivers off
// RULE6: shutdown low clears every internal register to zero; the code loads RESET_STATE instead, with fsm at P2S_OFF (3'h1) and oe_n high
// RULE7: slot n starts n sevenths after forwarded clock rise
// RULE8: forwarded clock high four slots, low three slots
// RULE9: lane data valid only after lock time once shutdown rises
// RULE10: shutdown falling leaves forwarded clock low promptly
// RULE11: host pixel clock must lie between 31 and 75 MHz
// RULE12: host pixel clock high time between 40 and 60 percent
// RULE13: slot timing follows a spread-spectrum modulated input clock
// RULE14: word is sent unchanged with no coding overhead
// RULE15: lane k carries bits 7k..7k+6, lowest bit in slot 0
module p2s_top #(
    parameter int LOCK_CYCLES = p2s_pkg::LOCK_CYCLES_DFLT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic host_pixel_clock,
    input wire logic [p2s_pkg::WORD_W-1:0] parallel_word_in,
    input wire logic power_down_clear_n,
    output logic [p2s_pkg::LANES-1:0] serial_lane_pair,
    output logic forwarded_lane_clock,
    output logic lane_drive_oe_n
);
    typedef struct packed {
        p2s_pkg::p2s_fsm_e fsm;
        logic pclk_prev;
        logic [p2s_pkg::PER_W-1:0] per_cnt;
        logic [p2s_pkg::PER_W-1:0] period;
        logic [p2s_pkg::PER_W:0] acc;
        logic [2:0] slot;
        logic [p2s_pkg::LANES-1:0][p2s_pkg::SLOTS-1:0] shreg;
        logic [p2s_pkg::LOCK_W-1:0] lock_cnt;
        p2s_pkg::p2s_link_s out;
    } p2s_state_s;

    localparam p2s_state_s RESET_STATE = '{
        fsm: p2s_pkg::P2S_OFF,
        pclk_prev: 1'b0,
        per_cnt: '0,
        period: '0,
        acc: '0,
        slot: p2s_pkg::SLOT_FIRST,
        shreg: '0,
        lock_cnt: '0,
        out: '{lane: '0, fclk: 1'b0, oe_n: 1'b1}
    };
    localparam logic [p2s_pkg::LOCK_W-1:0] LOCK_LAST =
        p2s_pkg::LOCK_W'(LOCK_CYCLES - 1);

    p2s_state_s s;
    p2s_state_s next_s;
    p2s_pkg::p2s_pins_s pins;
    logic fall;
    logic slot_pulse;
    logic [p2s_pkg::PER_W:0] acc_step;
    logic run;

    // data passes the same two stages as the clock, so they stay aligned
    p2s_sync #(
        .W($bits(p2s_pkg::p2s_pins_s))
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .d({host_pixel_clock, parallel_word_in, power_down_clear_n}),
        .q(pins)
    );

    assign fall = s.pclk_prev & ~pins.pclk;
    assign run = (s.fsm == p2s_pkg::P2S_RUN);
    // phase accumulator stands in for the multiplying loop
    assign acc_step = s.acc + p2s_pkg::SLOT_STEP;
    assign slot_pulse = (acc_step >= {1'b0, s.period});

    always_comb begin
        next_s = s;
        if (!pins.pd_n) begin
            next_s = RESET_STATE; // RULE6
            next_s.out.fclk = 1'b0; // RULE10
            next_s.out.oe_n = 1'b1; // RULE5
        end else begin
            next_s.pclk_prev = pins.pclk;
            // period is re-measured every cycle so slow frequency sweeps
            // are tracked without a loop filter
            if (fall) begin
                next_s.period = s.per_cnt + 1'b1; // RULE13
                next_s.per_cnt = '0;
            end else if (s.per_cnt != p2s_pkg::PER_MAX) begin
                next_s.per_cnt = s.per_cnt + 1'b1;
            end
            case (s.fsm)
                p2s_pkg::P2S_OFF: begin
                    next_s.fsm = p2s_pkg::P2S_ACQUIRE;
                    next_s.lock_cnt = '0;
                end
                p2s_pkg::P2S_ACQUIRE: begin
                    next_s.lock_cnt = s.lock_cnt + 1'b1;
                    if (s.lock_cnt == LOCK_LAST) begin
                        next_s.fsm = p2s_pkg::P2S_RUN; // RULE9
                    end
                end
                p2s_pkg::P2S_RUN: begin
                    next_s.lock_cnt = s.lock_cnt;
                end
                default: begin
                    next_s.fsm = p2s_pkg::P2S_OFF;
                end
            endcase
            next_s.out.oe_n = ~run; // RULE9
            if (fall) begin
                // bits go out as presented, no coding
                next_s.shreg = pins.word; // RULE2 RULE14 RULE15
                for (int k = 0; k < p2s_pkg::LANES; k++) begin
                    next_s.out.lane[k] = run & pins.word[k*p2s_pkg::SLOTS];
                    next_s.shreg[k] = {1'b0,
                        pins.word[k*p2s_pkg::SLOTS+1 +: p2s_pkg::SLOTS-1]};
                end
                next_s.slot = p2s_pkg::SLOT_FIRST; // RULE7
                next_s.acc = '0;
                next_s.out.fclk = run; // RULE4
            end else if (slot_pulse && s.slot != p2s_pkg::SLOT_LAST) begin
                next_s.acc = acc_step - {1'b0, s.period}; // RULE3
                next_s.slot = s.slot + 1'b1;
                for (int k = 0; k < p2s_pkg::LANES; k++) begin
                    next_s.out.lane[k] = run & s.shreg[k][0]; // RULE1
                    next_s.shreg[k] = s.shreg[k] >> 1;
                end
                // clock only falls here: a lock reached mid-frame must not
                // raise it away from slot 0
                next_s.out.fclk = run && s.out.fclk &&
                    (s.slot + 1'b1) < p2s_pkg::SLOT_HIGH_END; // RULE8
            end else if (!slot_pulse) begin
                next_s.acc = acc_step;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign serial_lane_pair = s.out.lane;
    assign forwarded_lane_clock = s.out.fclk;
    assign lane_drive_oe_n = s.out.oe_n;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_off_clock_low;
        !pins.pd_n |=> !forwarded_lane_clock && lane_drive_oe_n;
    endproperty
    a_off_clock_low: assert property (p_off_clock_low) // RULE10
        else $error("clock or drivers active after shutdown");

    property p_off_stays_off;
        !pins.pd_n ##1 !pins.pd_n |-> lane_drive_oe_n && s.lock_cnt == '0;
    endproperty
    a_off_stays_off: assert property (p_off_stays_off) // RULE5
        else $error("drivers enabled during shutdown");

    property p_clear;
        !pins.pd_n |=> s.shreg == '0 && serial_lane_pair == '0;
    endproperty
    a_clear: assert property (p_clear) // RULE6
        else $error("registers not cleared in shutdown");

    property p_capture;
        pins.pd_n && fall && run |=> serial_lane_pair ==
            {$past(pins.word[14]), $past(pins.word[7]), $past(pins.word[0])};
    endproperty
    a_capture: assert property (p_capture) // RULE2
        else $error("slot 0 does not carry the captured low bits");

    property p_shift;
        pins.pd_n && run && !fall && slot_pulse && s.slot != 3'h6
            |=> serial_lane_pair[1] == $past(s.shreg[1][0]);
    endproperty
    a_shift: assert property (p_shift) // RULE1
        else $error("lane did not shift next bit");

    property p_slot_range;
        s.slot <= 3'h6;
    endproperty
    a_slot_range: assert property (p_slot_range) // RULE3
        else $error("slot index beyond last slot");

    property p_clk_rise;
        $rose(forwarded_lane_clock) |-> $past(fall) && s.slot == 3'h0;
    endproperty
    a_clk_rise: assert property (p_clk_rise) // RULE7
        else $error("forwarded clock rose off the slot 0 boundary");

    property p_clk_shape;
        pins.pd_n && run && !fall && slot_pulse && s.slot == 3'h3
            |=> !forwarded_lane_clock && s.slot == 3'h4;
    endproperty
    a_clk_shape: assert property (p_clk_shape) // RULE8
        else $error("forwarded clock not low from slot 4");

    property p_lock;
        $fell(lane_drive_oe_n) |-> $past(run) && s.lock_cnt == LOCK_LAST + 1'b1;
    endproperty
    a_lock: assert property (p_lock) // RULE9
        else $error("drivers enabled before lock time");

    property p_idle_lanes;
        !run |=> serial_lane_pair == '0;
    endproperty
    a_idle_lanes: assert property (p_idle_lanes) // RULE9
        else $error("lane data shown before lock");

    c_run: cover property ($fell(lane_drive_oe_n));
    c_last_slot: cover property (run && s.slot == 3'h6 ##1 fall);
    c_shutdown_run: cover property (run ##1 !pins.pd_n);
endmodule : p2s_top
